//--- pkg/periph_pkg.sv
// shared constants and carrier types for the peripheral register framework
`default_nettype none

package periph_pkg;

  // ------------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int OFS_W = 12;
  localparam int ID_W = 5;
  localparam int N_TASK = 4;
  localparam int N_EVT = 4;
  localparam int WORD_LSB = 2;

  // ------------------------------------------------------------------
  // address window and identifier
  // ------------------------------------------------------------------
  localparam logic [31:0] WIN_BYTES = 32'h0000_1000;
  localparam logic [31:0] ID0_BASE = 32'h4000_0000;
  localparam logic [31:0] DEF_BASE = 32'h4000_0000;

  // ------------------------------------------------------------------
  // register offsets inside the window
  // ------------------------------------------------------------------
  localparam logic [11:0] OFS_TASK = 12'h000;
  localparam logic [11:0] OFS_EVENT = 12'h100;
  localparam logic [11:0] OFS_SHORTS = 12'h200;
  localparam logic [11:0] OFS_INTERRUPT_ENABLE_REG = 12'h300;
  localparam logic [11:0] OFS_INTERRUPT_ENABLE_REG_SET = 12'h304;
  localparam logic [11:0] OFS_INTERRUPT_ENABLE_REG_CLR = 12'h308;
  localparam logic [11:0] OFS_ENABLE = 12'h500;

  // ------------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------------
  localparam int TRIG_BIT = 0;
  localparam int ENABLE_BIT = 0;
  localparam logic [N_EVT-1:0] INTERRUPT_ENABLE_REG_RST = 4'h0;
  localparam logic [N_TASK-1:0] SHORTS_RST = 4'h0;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam int CLR_LAT_MAX = 4;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_t;

endpackage

`default_nettype wire

//--- logic/peripheral_task_event_interface.sv
// task, event, shortcut and interrupt register framework of one peripheral
`default_nettype none

module peripheral_task_event_interface
  import periph_pkg::*;
#(
  parameter logic [31:0] BASE_ADDR = DEF_BASE
) (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire bus_req_t BUS_REQ,
  output logic [DATA_W-1:0] RDATA,
  input wire logic [N_TASK-1:0] TASK_IN,
  input wire logic [N_EVT-1:0] EVENT_IN,
  output logic [N_TASK-1:0] TASK_PULSE,
  output logic [N_EVT-1:0] EVENT_PULSE,
  output logic IRQ,
  output logic ENABLED,
  output logic [ID_W-1:0] PERIPH_ID
);

  // ------------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------------

  // true when ofs is an aligned word inside a group of n registers
  function automatic logic in_group(
    input logic [OFS_W-1:0] ofs,
    input logic [OFS_W-1:0] base,
    input int n
  );
    logic [OFS_W-1:0] top;
    top = base + OFS_W'(n << WORD_LSB);
    in_group = (ofs >= base) && (ofs < top)
      && (ofs[WORD_LSB-1:0] == 2'h0);
  endfunction

  // one-hot of the register selected inside a group
  function automatic logic [N_TASK-1:0] group_hot(
    input logic [OFS_W-1:0] ofs,
    input logic [OFS_W-1:0] base
  );
    logic [OFS_W-1:0] diff;
    diff = ofs - base;
    group_hot = N_TASK'(1) << diff[WORD_LSB+1:WORD_LSB];
  endfunction

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic enable_reg;
  logic [N_EVT-1:0] event_reg;
  logic [N_EVT-1:0] interrupt_enable_reg_reg;
  logic [N_TASK-1:0] shorts_reg;
  logic [N_TASK-1:0] task_in_q;
  logic [N_EVT-1:0] event_in_q;

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  logic hit;
  logic [OFS_W-1:0] ofs;
  logic wr_hit;
  logic rd_hit;
  logic task_sel;
  logic event_sel;
  logic [N_TASK-1:0] sel_hot;

  // only the window bits take part; the low 12 bits pick the word
  assign hit = BUS_REQ.addr[ADDR_W-1:OFS_W] == BASE_ADDR[ADDR_W-1:OFS_W];
  assign ofs = BUS_REQ.addr[OFS_W-1:0];
  assign wr_hit = BUS_REQ.wr && hit;
  assign rd_hit = BUS_REQ.rd && hit;
  assign task_sel = in_group(ofs, OFS_TASK, N_TASK);
  assign event_sel = in_group(ofs, OFS_EVENT, N_EVT);
  assign sel_hot = group_hot(ofs, event_sel ? OFS_EVENT : OFS_TASK);

  // ------------------------------------------------------------------
  // task and event triggers
  // ------------------------------------------------------------------
  logic [N_TASK-1:0] task_wr;
  logic [N_TASK-1:0] task_tog;
  logic [N_EVT-1:0] evt_gen;
  logic [N_TASK-1:0] short_trig;
  logic [N_TASK-1:0] task_fire;
  logic [N_EVT-1:0] evt_clr;

  // a written zero is no trigger at all
  assign task_wr = (wr_hit && task_sel && BUS_REQ.wdata[TRIG_BIT])
    ? sel_hot : '0;
  assign task_tog = TASK_IN ^ task_in_q;

  // disabled peripheral swallows its event toggles
  assign evt_gen = (EVENT_IN ^ event_in_q) & {N_EVT{enable_reg}};

  // pairing is wired: shortcut k links event k to task k
  assign short_trig = evt_gen & shorts_reg;

  assign task_fire = (task_wr | task_tog | short_trig)
    & {N_TASK{enable_reg}};

  assign evt_clr = (wr_hit && event_sel
    && BUS_REQ.wdata == ZERO_WORD) ? sel_hot : '0;

  // ------------------------------------------------------------------
  // toggle detectors
  // ------------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      task_in_q <= '0;
      event_in_q <= '0;
    end else begin
      task_in_q <= TASK_IN;
      event_in_q <= EVENT_IN;
    end
  end

  // ------------------------------------------------------------------
  // task and event pulses
  // ------------------------------------------------------------------

  // the shortcut reaches the task in the same cycle as the event pulse, ahead of
  // any loop through the external interconnect
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      TASK_PULSE <= '0;
    end else begin
      TASK_PULSE <= task_fire;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      EVENT_PULSE <= '0;
    end else begin
      EVENT_PULSE <= evt_gen;
    end
  end

  // ------------------------------------------------------------------
  // event registers
  // ------------------------------------------------------------------

  // a new event in the clearing cycle wins, so it is never lost
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      event_reg <= '0;
    end else begin
      event_reg <= (event_reg & ~evt_clr) | evt_gen;
    end
  end

  // ------------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      enable_reg <= 1'b0;
    end else if (wr_hit && ofs == OFS_ENABLE) begin
      enable_reg <= BUS_REQ.wdata[ENABLE_BIT];
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      shorts_reg <= SHORTS_RST;
    end else if (wr_hit && ofs == OFS_SHORTS) begin
      shorts_reg <= BUS_REQ.wdata[N_TASK-1:0];
    end
  end

  // main, set alias and clear alias sit on three adjacent words
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      interrupt_enable_reg_reg <= INTERRUPT_ENABLE_REG_RST;
    end else if (wr_hit) begin
      unique case (ofs)
        OFS_INTERRUPT_ENABLE_REG: begin
          interrupt_enable_reg_reg <= BUS_REQ.wdata[N_EVT-1:0];
        end
        OFS_INTERRUPT_ENABLE_REG_SET: begin
          interrupt_enable_reg_reg <= interrupt_enable_reg_reg | BUS_REQ.wdata[N_EVT-1:0];
        end
        OFS_INTERRUPT_ENABLE_REG_CLR: begin
          interrupt_enable_reg_reg <= interrupt_enable_reg_reg & ~BUS_REQ.wdata[N_EVT-1:0];
        end
        default: begin
          interrupt_enable_reg_reg <= interrupt_enable_reg_reg;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] rd_next;
  logic [N_EVT-1:0] evt_bit;

  assign evt_bit = event_reg & sel_hot;

  // task words and unmapped words read as zero
  always_comb begin
    rd_next = ZERO_WORD;
    if (rd_hit) begin
      if (event_sel) begin
        rd_next = DATA_W'(|evt_bit);
      end else if (ofs == OFS_SHORTS) begin
        rd_next = DATA_W'(shorts_reg);
      end else if (ofs == OFS_INTERRUPT_ENABLE_REG || ofs == OFS_INTERRUPT_ENABLE_REG_SET
          || ofs == OFS_INTERRUPT_ENABLE_REG_CLR) begin
        rd_next = DATA_W'(interrupt_enable_reg_reg);
      end else if (ofs == OFS_ENABLE) begin
        rd_next = DATA_W'(enable_reg);
      end
    end
  end

  // data stand for the one cycle after the strobe only
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      RDATA <= ZERO_WORD;
    end else begin
      RDATA <= rd_next;
    end
  end

  // ------------------------------------------------------------------
  // interrupt, status and identifier
  // ------------------------------------------------------------------
  logic irq_pend;

  // each event is gated by its own enable bit into the one line
  assign irq_pend = |(event_reg & interrupt_enable_reg_reg);

  // one register stage keeps the drop well inside the four cycles
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= irq_pend;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      ENABLED <= 1'b0;
    end else begin
      ENABLED <= enable_reg;
    end
  end

  logic [31:0] id_span;

  assign id_span = (BASE_ADDR - ID0_BASE) / WIN_BYTES;

  // reset to zero, then loaded from the base on every edge
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      PERIPH_ID <= '0;
    end else begin
      PERIPH_ID <= id_span[ID_W-1:0];
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);

  a_task_write_fires: assert property (
    (task_wr != '0 && enable_reg)
      |=> (TASK_PULSE & $past(task_wr)) == $past(task_wr))
    else $error("written task did not pulse");

  a_task_zero_idle: assert property (
    (wr_hit && task_sel && !BUS_REQ.wdata[TRIG_BIT]
      && task_tog == '0 && short_trig == '0)
      |=> TASK_PULSE == '0)
    else $error("zero write fired a task");

  a_disabled_quiet: assert property (
    !enable_reg |=> (TASK_PULSE == '0 && EVENT_PULSE == '0))
    else $error("disabled block produced a pulse");

  a_event_stays_set: assert property (
    (event_reg & ~evt_clr) != '0
      |=> (event_reg & $past(event_reg & ~evt_clr))
        == $past(event_reg & ~evt_clr))
    else $error("event bit dropped without a zero write");

  a_event_sets_reg: assert property (
    evt_gen != '0 |=> (event_reg & $past(evt_gen)) == $past(evt_gen))
    else $error("event did not set its register");

  a_event_repeats: assert property (
    (evt_gen & event_reg) != '0
      |=> (EVENT_PULSE & $past(evt_gen)) == $past(evt_gen))
    else $error("event pulse lost while register set");

  a_shortcut_fires: assert property (
    short_trig != '0
      |=> (TASK_PULSE & $past(short_trig)) == $past(short_trig))
    else $error("shortcut did not fire its task");

  a_alias_reads: assert property (
    (rd_hit && (ofs == OFS_INTERRUPT_ENABLE_REG_SET || ofs == OFS_INTERRUPT_ENABLE_REG_CLR))
      |=> RDATA == DATA_W'($past(interrupt_enable_reg_reg)))
    else $error("alias read differs from main register");

  a_set_alias_or: assert property (
    (wr_hit && ofs == OFS_INTERRUPT_ENABLE_REG_SET)
      |=> interrupt_enable_reg_reg == ($past(interrupt_enable_reg_reg) | $past(BUS_REQ.wdata[N_EVT-1:0])))
    else $error("set alias did not or in the ones");

  a_irq_drops: assert property (
    !irq_pend ##1 !irq_pend |-> ##[0:3] !IRQ)
    else $error("interrupt stayed high after clear");

  a_outside_zero: assert property (
    (BUS_REQ.rd && !hit) |=> RDATA == ZERO_WORD)
    else $error("read outside window returned data");

  c_task_write: cover property (task_wr != '0 && enable_reg);
  c_shortcut: cover property (short_trig != '0);
  c_irq_rise: cover property (!IRQ ##1 IRQ);
  c_event_clear: cover property ((event_reg & evt_clr) != '0);

endmodule

`default_nettype wire

//--- sim/peer_model.sv
// peer peripheral that toggles the task and event signal lines
`default_nettype none

module peer_model
  import periph_pkg::*;
(
  input wire logic clk,
  output logic [N_TASK-1:0] task_sig,
  output logic [N_EVT-1:0] event_sig
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    task_sig = '0;
    event_sig = '0;
  end

  // both edges count, so a toggle is one flip of the level
  task automatic toggle_task(input int i);
    @(posedge clk);
    task_sig[i] <= ~task_sig[i];
  endtask

  task automatic toggle_event(input int i);
    @(posedge clk);
    event_sig[i] <= ~event_sig[i];
  endtask
endmodule

`default_nettype wire

//--- sim/peripheral_task_event_interface_tb.sv
// self-checking bench for the peripheral task and event register framework
`default_nettype none

module peripheral_task_event_interface_tb
  import periph_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] BASE = 32'h4001_F000;
  logic ref_clk;
  logic nrst;
  bus_req_t req;
  logic [31:0] rdata;
  logic [N_TASK-1:0] task_in;
  logic [N_EVT-1:0] event_in;
  logic [N_TASK-1:0] task_pulse;
  logic [N_EVT-1:0] event_pulse;
  logic irq;
  logic enabled;
  logic [ID_W-1:0] periph_id;
  logic [N_TASK-1:0] tp;
  logic [N_EVT-1:0] ep;
  logic [31:0] d;
  int bad_count = 0;
  int total_checks = 0;

  peripheral_task_event_interface #(.BASE_ADDR(BASE)) DUT (
    .REF_CLK(ref_clk), .NRST(nrst), .BUS_REQ(req), .RDATA(rdata),
    .TASK_IN(task_in), .EVENT_IN(event_in), .TASK_PULSE(task_pulse),
    .EVENT_PULSE(event_pulse), .IRQ(irq), .ENABLED(enabled), .PERIPH_ID(periph_id)
  );

  peer_model peer (.clk(ref_clk), .task_sig(task_in), .event_sig(event_in));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] at(input logic [11:0] ofs);
    return {BASE[31:12], ofs};
  endfunction

  task automatic wr(input logic [31:0] ad, input logic [31:0] wd);
    @(posedge ref_clk);
    req <= '{1'b1, 1'b0, ad, wd};
    @(posedge ref_clk);
    req.wr <= 1'b0;
    #1;
    tp = task_pulse;
    ep = event_pulse;
  endtask

  task automatic rd(input logic [31:0] ad, output logic [31:0] rv);
    @(posedge ref_clk);
    req <= '{1'b0, 1'b1, ad, ZERO_WORD};
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1;
    rv = rdata;
  endtask

  task automatic rchk(input logic [11:0] ofs, input logic [31:0] exp);
    rd(at(ofs), d);
    chk(d, exp);
  endtask

  task automatic after_edge();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic t_reset();
    // the last base of the identifier range maps to identifier 31
    chk(32'(periph_id), 32'h0000_001F);
    chk(32'({irq, enabled}), 32'h0);
    rchk(OFS_INTERRUPT_ENABLE_REG, 32'(INTERRUPT_ENABLE_REG_RST));
    rchk(OFS_SHORTS, 32'(SHORTS_RST));
  endtask

  task automatic t_disabled();
    wr(at(OFS_TASK), 32'h1);
    chk(32'(tp), 32'h0);
    peer.toggle_task(1);
    after_edge();
    chk(32'(task_pulse), 32'h0);
    peer.toggle_event(1);
    after_edge();
    chk(32'(event_pulse), 32'h0);
    rchk(OFS_EVENT + 12'h004, 32'h0);
  endtask

  task automatic t_tasks();
    // sole user of this identifier, configuration settled before enable
    wr(at(OFS_ENABLE), 32'h1);
    after_edge();
    chk(32'(enabled), 32'h1);
    for (int i = 0; i < N_TASK; i++) begin
      wr(at(OFS_TASK + 12'(4 * i)), 32'h1);
      chk(32'(tp), 32'h1 << i);
      wr(at(OFS_TASK + 12'(4 * i)), 32'h0);
      chk(32'(tp), 32'h0);
      rchk(OFS_TASK + 12'(4 * i), 32'h0);
      peer.toggle_task(i);
      after_edge();
      chk(32'(task_pulse), 32'h1 << i);
    end
  endtask

  task automatic t_events();
    for (int i = 0; i < N_EVT; i++) begin
      peer.toggle_event(i);
      after_edge();
      chk(32'(event_pulse), 32'h1 << i);
      chk(32'(task_pulse), 32'h0);
      rchk(OFS_EVENT + 12'(4 * i), 32'h1);
      peer.toggle_event(i);
      after_edge();
      chk(32'(event_pulse), 32'h1 << i);
      wr(at(OFS_EVENT + 12'(4 * i)), 32'h1);
      chk(32'(ep), 32'h0);
      rchk(OFS_EVENT + 12'(4 * i), 32'h1);
      wr(at(OFS_EVENT + 12'(4 * i)), 32'h0);
      rchk(OFS_EVENT + 12'(4 * i), 32'h0);
    end
  endtask

  task automatic t_aliases();
    wr(at(OFS_INTERRUPT_ENABLE_REG_SET), 32'h5);
    rchk(OFS_INTERRUPT_ENABLE_REG, 32'h5);
    rchk(OFS_INTERRUPT_ENABLE_REG_SET, 32'h5);
    wr(at(OFS_INTERRUPT_ENABLE_REG_CLR), 32'h1);
    rchk(OFS_INTERRUPT_ENABLE_REG_CLR, 32'h4);
    wr(at(OFS_INTERRUPT_ENABLE_REG_SET), 32'h0);
    wr(at(OFS_INTERRUPT_ENABLE_REG_CLR), 32'h0);
    rchk(OFS_INTERRUPT_ENABLE_REG, 32'h4);
    wr(at(OFS_INTERRUPT_ENABLE_REG), 32'hA);
    rchk(OFS_INTERRUPT_ENABLE_REG, 32'hA);
  endtask

  task automatic t_irq();
    wr(at(OFS_INTERRUPT_ENABLE_REG), 32'h4);
    peer.toggle_event(1);
    repeat (3) after_edge();
    chk(32'(irq), 32'h0);
    peer.toggle_event(2);
    repeat (3) after_edge();
    chk(32'(irq), 32'h1);
    wr(at(OFS_EVENT + 12'h008), 32'h0);
    repeat (CLR_LAT_MAX) after_edge();
    chk(32'(irq), 32'h0);
    peer.toggle_event(2);
    repeat (3) after_edge();
    chk(32'(irq), 32'h1);
    wr(at(OFS_INTERRUPT_ENABLE_REG_CLR), 32'hFFFF_FFFF);
    repeat (CLR_LAT_MAX) after_edge();
    chk(32'(irq), 32'h0);
  endtask

  task automatic t_shorts();
    for (int k = 0; k < N_TASK; k++) begin
      wr(at(OFS_SHORTS), 32'h1 << k);
      peer.toggle_event(k);
      after_edge();
      chk(32'(task_pulse), 32'h1 << k);
      chk(32'(event_pulse), 32'h1 << k);
    end
    wr(at(OFS_SHORTS), 32'hFFFF_FFFF);
    rchk(OFS_SHORTS, 32'hF);
  endtask

  task automatic t_window();
    // a known nonzero value makes a stray hit from outside visible
    wr(at(OFS_INTERRUPT_ENABLE_REG), 32'h3);
    wr(BASE + WIN_BYTES + 32'(OFS_INTERRUPT_ENABLE_REG), 32'hF);
    rchk(OFS_INTERRUPT_ENABLE_REG, 32'h3);
    rd(BASE - WIN_BYTES + 32'(OFS_INTERRUPT_ENABLE_REG), d);
    chk(d, 32'h0);
    wr(at(12'hFFC), 32'hFFFF_FFFF);
    rchk(12'hFFC, 32'h0);
    wr(at(OFS_ENABLE), 32'h0);
    after_edge();
    chk(32'(enabled), 32'h0);
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    req = '{1'b0, 1'b0, 32'h0, 32'h0};
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    after_edge();
    t_reset();
    t_disabled();
    t_tasks();
    t_events();
    t_aliases();
    t_irq();
    t_shorts();
    t_window();
    wrap_up();
  end

  // whole run is under two hundred cycles; this limit leaves wide margin
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
endmodule

`default_nettype wire
